/* hdl/ubrg_pkg.sv */
// Package of constants and types for the baud rate generator
package ubrg_pkg;
	// Register byte offsets
	localparam logic [7:0] UBRG_MODE_OFF    = 8'h00;
	localparam logic [7:0] UBRG_BAUD_OFF    = 8'h04;
	localparam logic [7:0] UBRG_STATUS_OFF  = 8'h08;
	localparam logic [7:0] UBRG_CTRL_OFF    = 8'h0c;
	// Mode register fields
	localparam int UBRG_CLKS_LSB   = 4;
	localparam int UBRG_OVER_BIT   = 19;
	localparam int UBRG_SYNC_BIT   = 8;
	localparam logic [3:0] UBRG_MODE_FIELD_LSB = 4'h0;
	localparam logic [3:0] UBRG_MODE_NORMAL    = 4'h0;
	// Baud register fields
	localparam int UBRG_CD_LSB     = 0;
	localparam int UBRG_FP_LSB     = 16;
	// Control register bits
	localparam int UBRG_EN_BIT     = 0;
	localparam int UBRG_RI_BIT     = 1;
	localparam int UBRG_DSR_BIT    = 2;
	localparam int UBRG_DCD_BIT    = 3;
	localparam int UBRG_CTS_BIT    = 4;
	// Widths and constants
	localparam int UBRG_CD_W       = 16;
	localparam int UBRG_FP_W       = 3;
	localparam int UBRG_DIV_FIX    = 8;
	localparam logic [31:0] UBRG_ZERO32 = 32'h0000_0000;
	localparam logic [1:0] UBRG_RESP_OKAY   = 2'h0;
	localparam logic [1:0] UBRG_RESP_SLVERR = 2'h2;
	// Clock source selection codes
	typedef enum logic [1:0] {
		UBRG_SRC_MCK   = 2'h0,
		UBRG_SRC_DIV   = 2'h1,
		UBRG_SRC_EXT2  = 2'h2,
		UBRG_SRC_EXT   = 2'h3
	} ubrg_src_t;
endpackage

/* hdl/ubrg_div_if.sv */
// Interface carrying divider configuration and ticks
`timescale 1ns/1ps
interface ubrg_div_if;
	logic        src_tick;
	logic [15:0] divisor;
	logic [2:0]  frac;
	logic        frac_en;
	logic        div_tick;
	modport ctl (output src_tick, output divisor, output frac, output frac_en, input div_tick);
	modport div (input src_tick, input divisor, input frac, input frac_en, output div_tick);
endinterface

/* hdl/ubrg_divider.sv */
// Integer and fractional divider producing single-cycle ticks
`timescale 1ns/1ps
module ubrg_divider
	import ubrg_pkg::*;
(
	// Clock and reset
	input  wire logic aclk,
	input  wire logic aresetn,
	// Divider link
	ubrg_div_if.div   dif
);
	typedef struct packed {
		logic [15:0] cnt;
		logic [2:0]  acc;
		logic        extra;
		logic        tick;
	} ubrg_div_st_t;

	ubrg_div_st_t st_reg;
	ubrg_div_st_t st_next;

	// Count source ticks up to the divisor, restart from zero and stretch by the fraction
	always_comb begin
		logic [3:0] sum;
		sum = 4'h0;
		st_next = st_reg;
		st_next.tick = 1'b0;
		if (dif.divisor == 16'h0000) begin
			st_next.cnt = 16'h0000;
		end else if (dif.src_tick) begin
			if (dif.divisor == 16'h0001 && !dif.frac_en) begin
				st_next.tick = 1'b1;
			end else if (st_reg.extra) begin
				st_next.extra = 1'b0;
				st_next.tick = 1'b1;
				st_next.cnt = 16'h0000;
			end else if (st_reg.cnt + 16'h0001 >= dif.divisor) begin
				st_next.cnt = 16'h0000;
				sum = {1'b0, st_reg.acc} + {1'b0, dif.frac};
				st_next.acc = sum[2:0];
				if (dif.frac_en && sum[3]) begin
					st_next.extra = 1'b1;
				end else begin
					st_next.tick = 1'b1;
				end
			end else begin
				st_next.cnt = st_reg.cnt + 16'h0001;
			end
		end
	end

	// State register; without a source tick only the tick clears, plus the count on a zero divisor
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign dif.div_tick = st_reg.tick;

	// Zero divisor silences the divider; divisor one without fraction passes every source tick
	property p_zero_silent;
		@(posedge aclk) disable iff (!aresetn)
		(dif.divisor == 16'h0000) [*2] |-> !dif.div_tick;
	endproperty
	a_zero_silent: assert property (p_zero_silent)
		else $error("tick with zero divisor");
	property p_bypass;
		@(posedge aclk) disable iff (!aresetn)
		(dif.src_tick && dif.divisor == 16'h0001 && !dif.frac_en) |=> dif.div_tick;
	endproperty
	a_bypass: assert property (p_bypass)
		else $error("bypass did not pass source tick");
endmodule

/* hdl/ubrg_top.sv */
// Baud rate generator top with AXI4-Lite register slave
`timescale 1ns/1ps
module ubrg_top
	import ubrg_pkg::*;
#(
	parameter int MCK_DIV       = UBRG_DIV_FIX,
	parameter bit HAS_MODEM     = 1'b0
)(
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// AXI4-Lite write address and data
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// AXI4-Lite read
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Serial clock pin and modem status inputs (active low)
	input  wire logic        sck_in,
	input  wire logic        ri_n,
	input  wire logic        dsr_n,
	input  wire logic        dcd_n,
	input  wire logic        cts_n,
	// Generated ticks
	output logic             sample_tick,
	output logic             baud_tick
);
	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        aw_got;
		logic        w_got;
		logic [7:0]  awaddr;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
		logic [31:0] mode;
		logic [31:0] baud;
		logic        clk_en;
		logic [4:0]  modem_mask;
		logic [3:0]  pre_cnt;
		logic        sck_d;
		logic [3:0]  os_cnt;
		logic        sample;
		logic        bit_tick;
	} ubrg_st_t;

	ubrg_st_t st_reg;
	ubrg_st_t st_next;
	ubrg_div_if dif ();

	// Write byte lanes into a word
	function automatic logic [31:0] ubrg_merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction

	logic       over;
	logic       sync_mode;
	logic       normal;
	ubrg_src_t  src;
	logic       src_tick;
	logic [3:0] os_last;
	logic [31:0] status_word;

	// Field decode from the mode register
	assign src       = ubrg_src_t'(st_reg.mode[UBRG_CLKS_LSB +: 2]);
	assign over      = st_reg.mode[UBRG_OVER_BIT];
	assign sync_mode = st_reg.mode[UBRG_SYNC_BIT];
	assign normal    = (st_reg.mode[UBRG_MODE_FIELD_LSB +: 4] == UBRG_MODE_NORMAL);
	assign os_last   = over ? 4'h7 : 4'hf;

	// Modem status only visible when pins exist
	assign status_word = {27'h0,
		HAS_MODEM ? ~{cts_n, dcd_n, dsr_n, ri_n} & st_reg.modem_mask[4:1] : 4'h0,
		st_reg.clk_en};

	// Source tick selection; ticks only while the clock is enabled
	always_comb begin
		src_tick = 1'b0;
		if (st_reg.clk_en) begin
			case (src)
				UBRG_SRC_MCK: src_tick = 1'b1;
				UBRG_SRC_DIV: src_tick = (st_reg.pre_cnt == 4'(MCK_DIV - 1));
				default:      src_tick = sck_in && !st_reg.sck_d;
			endcase
		end
	end

	assign dif.src_tick = src_tick;
	assign dif.divisor  = st_reg.baud[UBRG_CD_LSB +: UBRG_CD_W];
	assign dif.frac     = st_reg.baud[UBRG_FP_LSB +: UBRG_FP_W];
	assign dif.frac_en  = normal && !sync_mode && (dif.frac != 3'h0);

	ubrg_divider u_div (
		.aclk    (aclk),
		.aresetn (aresetn),
		.dif     (dif)
	);

	// Bus handling, prescaler and oversampling
	always_comb begin
		st_next = st_reg;
		st_next.sample = 1'b0;
		st_next.bit_tick = 1'b0;
		// Write address and data, either order
		if (s_axi_awvalid && st_reg.awready) begin
			st_next.aw_got = 1'b1;
			st_next.awaddr = s_axi_awaddr;
			st_next.awready = 1'b0;
		end
		if (s_axi_wvalid && st_reg.wready) begin
			st_next.w_got = 1'b1;
			st_next.wdata = s_axi_wdata;
			st_next.wstrb = s_axi_wstrb;
			st_next.wready = 1'b0;
		end
		if (st_reg.aw_got && st_reg.w_got && !st_reg.bvalid) begin
			st_next.bvalid = 1'b1;
			st_next.bresp = UBRG_RESP_OKAY;
			st_next.aw_got = 1'b0;
			st_next.w_got = 1'b0;
			// Writes land regardless of the clock enable
			if (st_reg.awaddr == UBRG_MODE_OFF) begin
				st_next.mode = ubrg_merge(st_reg.mode, st_reg.wdata, st_reg.wstrb);
			end else if (st_reg.awaddr == UBRG_BAUD_OFF) begin
				st_next.baud = ubrg_merge(st_reg.baud, st_reg.wdata, st_reg.wstrb);
			end else if (st_reg.awaddr == UBRG_CTRL_OFF) begin
				if (st_reg.wstrb[0]) begin
					st_next.clk_en = st_reg.wdata[UBRG_EN_BIT];
					st_next.modem_mask = {st_reg.wdata[UBRG_CTS_BIT], st_reg.wdata[UBRG_DCD_BIT],
						st_reg.wdata[UBRG_DSR_BIT], st_reg.wdata[UBRG_RI_BIT], 1'b0};
				end
			end else if (st_reg.awaddr != UBRG_STATUS_OFF) begin
				st_next.bresp = UBRG_RESP_SLVERR;
			end
		end
		if (st_reg.bvalid && s_axi_bready) begin
			st_next.bvalid = 1'b0;
			st_next.awready = 1'b1;
			st_next.wready = 1'b1;
		end
		// Read channel
		if (s_axi_arvalid && st_reg.arready) begin
			st_next.arready = 1'b0;
			st_next.rvalid = 1'b1;
			st_next.rresp = UBRG_RESP_OKAY;
			if (s_axi_araddr == UBRG_MODE_OFF) begin
				st_next.rdata = st_reg.mode;
			end else if (s_axi_araddr == UBRG_BAUD_OFF) begin
				st_next.rdata = st_reg.baud;
			end else if (s_axi_araddr == UBRG_STATUS_OFF) begin
				st_next.rdata = status_word;
			end else if (s_axi_araddr == UBRG_CTRL_OFF) begin
				st_next.rdata = {27'h0, st_reg.modem_mask[4:1], st_reg.clk_en};
			end else begin
				st_next.rdata = UBRG_ZERO32;
				st_next.rresp = UBRG_RESP_SLVERR;
			end
		end
		if (st_reg.rvalid && s_axi_rready) begin
			st_next.rvalid = 1'b0;
			st_next.arready = 1'b1;
		end
		// Prescaler and edge detect freeze when the clock is gated
		if (st_reg.clk_en) begin
			st_next.sck_d = sck_in;
			if (st_reg.pre_cnt == 4'(MCK_DIV - 1)) begin
				st_next.pre_cnt = 4'h0;
			end else begin
				st_next.pre_cnt = st_reg.pre_cnt + 4'h1;
			end
		end
		// Oversampling counter forms bit ticks in async mode
		if (dif.div_tick) begin
			st_next.sample = 1'b1;
			if (sync_mode) begin
				st_next.bit_tick = 1'b1;
			end else if (st_reg.os_cnt >= os_last) begin
				st_next.os_cnt = 4'h0;
				st_next.bit_tick = 1'b1;
			end else begin
				st_next.os_cnt = st_reg.os_cnt + 4'h1;
			end
		end
	end

	// State register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_reg <= '0;
			st_reg.awready <= 1'b1;
			st_reg.wready <= 1'b1;
			st_reg.arready <= 1'b1;
		end else begin
			st_reg <= st_next;
		end
	end

	// Outputs straight from flip-flops
	assign s_axi_awready = st_reg.awready;
	assign s_axi_wready  = st_reg.wready;
	assign s_axi_bvalid  = st_reg.bvalid;
	assign s_axi_bresp   = st_reg.bresp;
	assign s_axi_arready = st_reg.arready;
	assign s_axi_rvalid  = st_reg.rvalid;
	assign s_axi_rdata   = st_reg.rdata;
	assign s_axi_rresp   = st_reg.rresp;
	assign sample_tick   = st_reg.sample;
	assign baud_tick     = st_reg.bit_tick;

	// Tick, oversampling, mode and bus checks
	property p_div_to_sample;
		@(posedge aclk) disable iff (!aresetn)
		dif.div_tick |=> sample_tick;
	endproperty
	a_div_to_sample: assert property (p_div_to_sample)
		else $error("sample tick missing after divider tick");
	property p_bit_needs_sample;
		@(posedge aclk) disable iff (!aresetn)
		baud_tick |-> sample_tick;
	endproperty
	a_bit_needs_sample: assert property (p_bit_needs_sample)
		else $error("bit tick without sample tick");
	property p_gated;
		@(posedge aclk) disable iff (!aresetn)
		!st_reg.clk_en [*3] |-> !sample_tick;
	endproperty
	a_gated: assert property (p_gated)
		else $error("tick while clock gated");
	property p_over8;
		@(posedge aclk) disable iff (!aresetn)
		(!sync_mode && over && st_reg.os_cnt == 4'h7 && dif.div_tick) |=> baud_tick;
	endproperty
	a_over8: assert property (p_over8)
		else $error("missing bit tick at eight samples");
	property p_over16;
		@(posedge aclk) disable iff (!aresetn)
		(!sync_mode && !over && st_reg.os_cnt < 4'hf && dif.div_tick) |=> !baud_tick;
	endproperty
	a_over16: assert property (p_over16)
		else $error("bit tick before sixteen samples");
	property p_os_bound;
		@(posedge aclk) disable iff (!aresetn)
		(!sync_mode && over && dif.div_tick) |=> st_reg.os_cnt <= 4'h7;
	endproperty
	a_os_bound: assert property (p_os_bound)
		else $error("oversample count out of range");
	property p_zero_no_sample;
		@(posedge aclk) disable iff (!aresetn)
		(dif.divisor == 16'h0000) [*3] |-> !sample_tick;
	endproperty
	a_zero_no_sample: assert property (p_zero_no_sample)
		else $error("sample tick with zero divisor");
	property p_div_spacing;
		@(posedge aclk) disable iff (!aresetn)
		(src == UBRG_SRC_DIV && src_tick) |=> (src != UBRG_SRC_DIV || !src_tick);
	endproperty
	a_div_spacing: assert property (p_div_spacing)
		else $error("prescaled source ticks back to back");
	property p_frac_mode;
		@(posedge aclk) disable iff (!aresetn)
		!normal |-> !dif.frac_en;
	endproperty
	a_frac_mode: assert property (p_frac_mode)
		else $error("fraction active outside normal mode");
	property p_wr_resp;
		@(posedge aclk) disable iff (!aresetn)
		(st_reg.aw_got && st_reg.w_got && !st_reg.bvalid) |=> s_axi_bvalid;
	endproperty
	a_wr_resp: assert property (p_wr_resp)
		else $error("write not answered");
	property p_modem;
		@(posedge aclk) disable iff (!aresetn)
		!HAS_MODEM |-> status_word[4:1] == 4'h0;
	endproperty
	a_modem: assert property (p_modem)
		else $error("absent modem pin visible");
endmodule

/* testbench/ubrg_far_end.sv */
// Far side model: remote device driving the serial clock pin and modem lines
`timescale 1ns/1ps
module ubrg_far_end #(
	parameter int HALF = 5
)(
	// Clock and reset
	input  wire logic       aclk,
	input  wire logic       aresetn,
	// Bench control
	input  wire logic       run,
	input  wire logic [3:0] modem_lvl,
	// Pins toward the device
	output logic            sck_in,
	output logic            ri_n,
	output logic            dsr_n,
	output logic            dcd_n,
	output logic            cts_n
);
	int cnt;

	// Each level lasts HALF master periods; clock stands low while not running
	always @(posedge aclk) begin
		if (!aresetn || !run) begin
			cnt <= 0;
			sck_in <= 1'b0;
		end else if (cnt == HALF - 1) begin
			cnt <= 0;
			sck_in <= ~sck_in;
		end else begin
			cnt <= cnt + 1;
		end
	end

	// No interrupt line leaves the block, so nothing here reacts to edges
	// Modem levels come straight from the bench
	assign {ri_n, dsr_n, dcd_n, cts_n} = modem_lvl;
endmodule

/* testbench/usart_baud_rate_generator_test.sv */
// Self-checking bench for the baud rate generator
`timescale 1ns/1ps
module usart_baud_rate_generator_test import ubrg_pkg::*;;
	localparam int SCK_P = 10;
	// Design and far side signals
	logic        aclk, aresetn, sck_in, ri_n, dsr_n, dcd_n, cts_n, sck_run;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [3:0]  s_axi_wstrb, modem_lvl;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready, sample_tick, baud_tick;
	int          error_cnt = 0, total_checks = 0, cyc_cnt = 0, seed = 50;
	int          cyc, bt, n, cd, fp, t0, t1, wr_cyc;

	ubrg_top #(.MCK_DIV(UBRG_DIV_FIX), .HAS_MODEM(1'b0)) u_dut (.aclk, .aresetn,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .sck_in, .ri_n, .dsr_n, .dcd_n, .cts_n,
		.sample_tick, .baud_tick);
	ubrg_far_end #(.HALF(SCK_P / 2)) u_far (.aclk, .aresetn, .run(sck_run), .modem_lvl,
		.sck_in, .ri_n, .dsr_n, .dcd_n, .cts_n);

	// Clock generation
	initial begin
		aclk = 1'b0;
		forever #4 aclk = ~aclk;
	end

	// Hang guard
	always @(posedge aclk) begin
		cyc_cnt <= cyc_cnt + 1;
		if (cyc_cnt == 20000) begin
			error_cnt++;
			print_verdict();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic print_verdict();
		$display("comparisons=%0d mismatches=%0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// Bus write: address and data offered together, each dropped once taken
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		rsp = s_axi_bresp;
		wr_cyc = cyc_cnt; // Count at the edge where the write landed
		s_axi_bready <= 1'b0;
		@(posedge aclk);
	endtask

	// Bus read
	task automatic axi_rd(input logic [7:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		rd = s_axi_rdata;
		rsp = s_axi_rresp;
		s_axi_rready <= 1'b0;
		@(posedge aclk);
	endtask

	// Skip w sample ticks, then count cycles and bit ticks over k sample ticks
	task automatic measure(input int w, input int k);
		n = 0;
		while (n < w) begin
			@(posedge aclk);
			#1;
			n += int'(sample_tick === 1'b1);
		end
		cyc = 0;
		bt = 0;
		n = 0;
		while (n < k) begin
			@(posedge aclk);
			#1;
			cyc++;
			n += int'(sample_tick === 1'b1);
			bt += int'(baud_tick === 1'b1);
		end
	endtask

	function automatic int exp_cyc(int k, int d, int f, int mult);
		return k * d * mult + (k / 8) * f * mult;
	endfunction

	// Main sequence
	initial begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, sck_run} = '0;
		{s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hf;
		modem_lvl = 4'h0;
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		for (int i = 0; i < 4; i++) begin
			axi_rd(8'(4 * i));
			check(rd, UBRG_ZERO32);
		end
		axi_rd(8'h10);
		check(rd, UBRG_ZERO32);
		check(rsp, UBRG_RESP_SLVERR);
		axi_wr(UBRG_CTRL_OFF, 32'h1f);
		axi_wr(UBRG_STATUS_OFF, 32'hffff_ffff);
		check(rsp, UBRG_RESP_OKAY);
		modem_lvl <= 4'($random(seed));
		n = 0;
		repeat (200) begin
			@(posedge aclk);
			#1;
			n += int'(sample_tick === 1'b1 || baud_tick === 1'b1);
		end
		check(n, 0);
		axi_rd(UBRG_STATUS_OFF);
		check(rd, 32'h1);
		$display("test reset and zero divisor done");
		for (int s = 0; s < 4; s++) begin
			cd = 2 + ($random(seed) & 7);
			sck_run <= (s >= 2);
			axi_wr(UBRG_MODE_OFF, 32'(s) << UBRG_CLKS_LSB);
			axi_wr(UBRG_BAUD_OFF, 32'(cd));
			measure(2, 4);
			check(cyc, exp_cyc(4, cd, 0, s == 0 ? 1 : s == 1 ? UBRG_DIV_FIX : SCK_P));
		end
		sck_run <= 1'b0;
		axi_wr(UBRG_MODE_OFF, 32'h0);
		axi_wr(UBRG_BAUD_OFF, 32'h1);
		measure(2, 8);
		check(cyc, 8);
		$display("test sources done");
		for (int m = 0; m < 3; m++) begin
			axi_wr(UBRG_MODE_OFF, m == 2 ? 32'h1 << UBRG_SYNC_BIT : 32'(m) << UBRG_OVER_BIT);
			axi_wr(UBRG_BAUD_OFF, 32'h3);
			measure(18, 16);
			check(bt, m == 2 ? 16 : m == 1 ? 2 : 1);
		end
		$display("test oversampling done");
		for (int f = 0; f < 2; f++) begin
			fp = 1 + (($random(seed) & 255) % 7);
			cd = 2 + ($random(seed) & 7);
			axi_wr(UBRG_MODE_OFF, 32'(f));
			axi_wr(UBRG_BAUD_OFF, (32'(fp) << UBRG_FP_LSB) | 32'(cd));
			measure(2, 8);
			check(cyc, exp_cyc(8, cd, f == 1 ? 0 : fp, 1));
		end
		$display("test fraction done");
		axi_wr(UBRG_MODE_OFF, 32'h0);
		axi_wr(UBRG_BAUD_OFF, 32'd60);
		measure(2, 0);
		t0 = cyc_cnt;
		axi_wr(UBRG_CTRL_OFF, 32'h0);
		t1 = wr_cyc;
		axi_wr(UBRG_MODE_OFF, 32'h1 << UBRG_OVER_BIT);
		axi_rd(UBRG_MODE_OFF);
		check(rd, 32'h1 << UBRG_OVER_BIT);
		repeat (40) @(posedge aclk);
		axi_wr(UBRG_CTRL_OFF, 32'h1);
		t1 = wr_cyc - t1; // Gated span: disable landing to enable landing
		measure(1, 0);
		check(cyc_cnt - t0, 60 + t1);
		$display("test clock gating done");
		print_verdict();
	end
endmodule
